//--- rtl/port_status_pkg.sv
// constants and types shared by the port status and configuration block
`default_nettype none

package port_status_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_CFG_LOW = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_ID_LOW = 8'h02;
  localparam logic [7:0] IDX_ID_HIGH = 8'h03;
  localparam logic [7:0] IDX_SELECT = 8'h10;
  localparam logic [7:0] IDX_MASK = 8'h11;
  localparam logic [7:0] IDX_ORDER = 8'h12;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h0C;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] POL_A_RST = 8'hFF;
  localparam logic [7:0] POL_B_RST = 8'hDF;
  localparam logic [3:0] MASK_RST = 4'h0;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CFG_PARITY_BIT = 7;
  localparam int CFG_ODD_BIT = 6;
  localparam int CFG_ROLE_BIT = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam int ST_DEC_END = 7;
  localparam int ST_B_CMP = 6;
  localparam int ST_B_SINGLE = 5;
  localparam int ST_B_END = 4;
  localparam int ST_B_EMPTY = 3;
  localparam int ST_A_EMPTY = 2;
  localparam int ST_A_SINGLE = 1;
  localparam int ST_A_END = 0;
  // mask register bits and held-event bits share this order
  localparam int MSK_A_END = 0;
  localparam int MSK_A_SINGLE = 1;
  localparam int MSK_B_END = 2;
  localparam int MSK_B_SINGLE = 3;

  // ------------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_COMPRESS = 3'h1,
    OP_COMP_BYPASS = 3'h2,
    OP_DECOMP = 3'h3,
    OP_DECOMP_BYPASS = 3'h4,
    OP_DECOMP_OUTDIS = 3'h5
  } op_mode_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_PORT_A = 2'h1,
    SEL_PORT_B = 2'h2
  } select_t;

  typedef enum logic [2:0] {
    DMA_RSVD = 3'h0,
    DMA_VENDOR = 3'h1,
    DMA_ATA = 3'h2,
    DMA_BURST = 3'h3
  } dma_mode_t;

endpackage : port_status_pkg

`default_nettype wire

//--- rtl/parity_unit.sv
// per-byte parity generation and check for one 16-bit data port
`default_nettype none

module parity_unit #(
  parameter int BYTES = 2
) (
  input wire logic [8*BYTES-1:0] data,
  input wire logic [BYTES-1:0] par_in,
  input wire logic check_en,
  input wire logic odd,
  output logic [BYTES-1:0] par_gen,
  output logic par_err
);

  logic [BYTES-1:0] mismatch;

  // ------------------------------------------------------------------
  // one parity bit per byte lane
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_lane
      // odd parity inverts the plain xor so the total count is odd
      assign par_gen[i] = (^data[8*i +: 8]) ^ odd;
      assign mismatch[i] = par_gen[i] ^ par_in[i];
    end
  endgenerate

  assign par_err = check_en & (|mismatch);

endmodule : parity_unit

`default_nettype wire

//--- rtl/port_status_config.sv
// status byte, port configuration, polarity and identity registers
// What this block does
// - with all four port masks set, port flags appear only at final word
// - decoder record-end sets on end code or code error, decompress only
// - decoder record-end clears on reset, new transfer, next record start
// - port-B compare flag follows count at least compare count
// - compress modes set port-B single-byte with record-end if one byte
// - decompress bypass sets port-B single-byte on last one-byte transfer
// - port-B record-end on last record byte out or in; invalid decompress
// - four port flags clear on reset, new transfer, next record first byte
// - port-B empty flag shows an empty port-B path; set by reset
// - port-A empty flag shows an empty port-A path; set by reset
// - port-A single-byte set on last one-byte record transfer
// - port-A record-end on length countdown zero or last byte out
// - port-A config bit 15 enables parity checking on port-A bus
// - port-A config bit 14 selects odd parity, cleared selects even
// - port-A DMA mode 001 vendor, 010 ATA, 011 burst, others reserved
// - port-B config bits 15 and 14 set parity enable and odd parity
// - port-B DMA mode uses the same encoding as port A
// - read-only identity readable only outside selection commands
// - port-A polarity bits set active low; reset 0xFF; port-A select
// - port-B polarity bits set active low; reset 0xDF; port-B select
//
// The APB slave port is this design's own decision.
`default_nettype none

module port_status_config
  import port_status_pkg::*;
#(
  parameter int ADDR_W = 12,
  // arbitrary neutral value, not a real part code
  parameter logic [15:0] CHIP_IDENT = 16'h5A21
) (
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transfer context from the command logic
  input wire logic [2:0] op_mode,
  input wire logic new_transfer,
  input wire logic final_word,
  // decoder events
  input wire logic dec_end_code,
  input wire logic dec_code_error,
  input wire logic dec_record_start,
  // port-B events and counters
  input wire logic [31:0] portb_count,
  input wire logic [31:0] portb_compare,
  input wire logic portb_last_byte,
  input wire logic portb_one_byte,
  input wire logic portb_first_byte,
  input wire logic portb_path_busy,
  // port-A events
  input wire logic porta_length_zero,
  input wire logic porta_last_byte,
  input wire logic porta_one_byte,
  input wire logic porta_first_byte,
  input wire logic porta_path_busy,
  // data buses and their parity lanes
  input wire logic [15:0] porta_data_bus,
  input wire logic [1:0] porta_par_in,
  input wire logic [15:0] portb_data_bus,
  input wire logic [1:0] portb_par_in,
  // raw control pins, normalised to active high by polarity
  input wire logic [7:0] porta_ctl_pins,
  input wire logic [7:0] portb_ctl_pins,
  output logic [7:0] porta_ctl_active,
  output logic [7:0] portb_ctl_active,
  // configuration outputs toward the port interfaces
  output logic [1:0] porta_par_gen,
  output logic [1:0] portb_par_gen,
  output logic porta_par_err,
  output logic portb_par_err,
  output logic [2:0] porta_dma_mode,
  output logic [2:0] portb_dma_mode,
  output logic porta_mode_valid,
  output logic portb_mode_valid,
  output logic byte_order_select
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] status_high_byte_r;
  logic [7:0] port_a_config_high_r;
  logic [7:0] port_b_config_high_r;
  logic [7:0] port_a_polarity_r;
  logic [7:0] port_b_polarity_r;
  logic [3:0] mask_r;
  logic [3:0] held_r;
  logic [1:0] command_register_r;
  logic byte_order_r;
  logic [31:0] rdata_r;
  logic err_r;

  op_mode_t mode;
  select_t sel;
  assign mode = op_mode_t'(op_mode);
  assign sel = select_t'(command_register_r);

  // ------------------------------------------------------------------
  // mode qualifiers
  // ------------------------------------------------------------------
  logic mode_comp;
  logic mode_decomp;
  logic mode_dbyp;
  logic b_flags_valid;
  assign mode_comp = (mode == OP_COMPRESS) || (mode == OP_COMP_BYPASS);
  assign mode_decomp = (mode == OP_DECOMP) || (mode == OP_DECOMP_OUTDIS);
  assign mode_dbyp = (mode == OP_DECOMP_BYPASS);
  assign b_flags_valid = mode_comp || mode_dbyp;

  // ------------------------------------------------------------------
  // raw record events, indexed like the mask bits
  // ------------------------------------------------------------------
  logic [3:0] evt;
  logic [3:0] clr;
  logic [3:0] fire;
  logic defer;

  always_comb begin
    evt = 4'h0;
    // compress modes: end when length countdown hits zero
    evt[MSK_A_END] = (mode_comp && porta_length_zero) ||
      ((mode_decomp || mode_dbyp) && porta_last_byte);
    evt[MSK_A_SINGLE] = porta_one_byte &&
      ((mode_comp && porta_last_byte) ||
       ((mode_decomp || mode_dbyp) && porta_last_byte));
    // port-B flags mean nothing in the two decompress modes
    evt[MSK_B_END] = b_flags_valid && portb_last_byte;
    evt[MSK_B_SINGLE] = portb_one_byte && portb_last_byte &&
      b_flags_valid;
  end

  assign clr[MSK_A_END] = porta_first_byte;
  assign clr[MSK_A_SINGLE] = porta_first_byte;
  assign clr[MSK_B_END] = portb_first_byte;
  assign clr[MSK_B_SINGLE] = portb_first_byte;

  // all four masks set: record events are held until the last word
  assign defer = &mask_r;
  assign fire = defer ? ((held_r | evt) & {4{final_word}}) : evt;

  // ------------------------------------------------------------------
  // held events for end-of-transfer reporting
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || new_transfer) begin
      held_r <= 4'h0;
    end else if (!defer || final_word) begin
      held_r <= 4'h0;
    end else begin
      held_r <= held_r | evt;
    end
  end

  // ------------------------------------------------------------------
  // status byte: set beats record-start and first-byte clears; new transfer clear beats set
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_high_byte_r <= STATUS_RST;
    end else begin
      status_high_byte_r[ST_B_EMPTY] <= !portb_path_busy;
      status_high_byte_r[ST_A_EMPTY] <= !porta_path_busy;
      if (new_transfer) begin
        status_high_byte_r[ST_DEC_END] <= 1'b0;
        status_high_byte_r[ST_B_CMP] <= 1'b0;
        status_high_byte_r[ST_A_END] <= 1'b0;
        status_high_byte_r[ST_A_SINGLE] <= 1'b0;
        status_high_byte_r[ST_B_END] <= 1'b0;
        status_high_byte_r[ST_B_SINGLE] <= 1'b0;
      end else begin
        status_high_byte_r[ST_B_CMP] <= (portb_count >= portb_compare);
        if (mode_decomp && (dec_end_code || dec_code_error)) begin
          status_high_byte_r[ST_DEC_END] <= 1'b1;
        end else if (dec_record_start) begin
          status_high_byte_r[ST_DEC_END] <= 1'b0;
        end
        status_high_byte_r[ST_A_END] <= fire[MSK_A_END] ||
          (status_high_byte_r[ST_A_END] && !clr[MSK_A_END]);
        status_high_byte_r[ST_A_SINGLE] <= fire[MSK_A_SINGLE] ||
          (status_high_byte_r[ST_A_SINGLE] && !clr[MSK_A_SINGLE]);
        status_high_byte_r[ST_B_END] <= fire[MSK_B_END] ||
          (status_high_byte_r[ST_B_END] && !clr[MSK_B_END]);
        status_high_byte_r[ST_B_SINGLE] <= fire[MSK_B_SINGLE] ||
          (status_high_byte_r[ST_B_SINGLE] && !clr[MSK_B_SINGLE]);
      end
    end
  end

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic [7:0] idx;
  logic [7:0] eff_idx;
  logic aligned;
  logic setup;
  logic wr_en;
  logic hit;
  logic [31:0] rd_nxt;

  assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
  assign idx = paddr[9:2];
  // byte order select swaps indices 0 and 1 and indices 2 and 3; higher indices are unchanged
  assign eff_idx = (idx < 8'h04) ? (idx ^ {7'h00, byte_order_r}) : idx;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && !err_r;
  assign pready = 1'b1;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    hit = aligned;
    unique case (eff_idx)
      IDX_CFG_LOW: begin
        rd_nxt = 32'h0000_0000;
      end
      IDX_STATUS: begin
        unique case (sel)
          SEL_PORT_A: rd_nxt[7:0] = port_a_config_high_r;
          SEL_PORT_B: rd_nxt[7:0] = port_b_config_high_r;
          default: rd_nxt[7:0] = status_high_byte_r;
        endcase
      end
      IDX_ID_LOW: begin
        unique case (sel)
          SEL_PORT_A: rd_nxt[7:0] = port_a_polarity_r;
          SEL_PORT_B: rd_nxt[7:0] = port_b_polarity_r;
          default: rd_nxt[7:0] = CHIP_IDENT[7:0];
        endcase
      end
      IDX_ID_HIGH: begin
        if (sel == SEL_NONE) begin
          rd_nxt[7:0] = CHIP_IDENT[15:8];
        end
      end
      IDX_SELECT: rd_nxt[1:0] = command_register_r;
      IDX_MASK: rd_nxt[3:0] = mask_r;
      IDX_ORDER: rd_nxt[0] = byte_order_r;
      default: hit = 1'b0;
    endcase
    if (!aligned) begin
      rd_nxt = 32'h0000_0000;
    end
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (setup) begin
      rdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      err_r <= !hit;
    end
  end

  assign prdata = rdata_r;
  assign pslverr = psel && penable && err_r;

  // ------------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      command_register_r <= SEL_NONE;
      mask_r <= MASK_RST;
      byte_order_r <= 1'b0;
    end else if (wr_en) begin
      if (eff_idx == IDX_SELECT) begin
        // unused code 2'h3 folds to no selection
        command_register_r <= (pwdata[1:0] == 2'h3) ? SEL_NONE : pwdata[1:0];
      end
      if (eff_idx == IDX_MASK) begin
        mask_r <= pwdata[3:0];
      end
      if (eff_idx == IDX_ORDER) begin
        byte_order_r <= pwdata[0];
      end
    end
  end

  // configuration and polarity: only reachable under the matching select
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_a_config_high_r <= CFG_RST;
      port_b_config_high_r <= CFG_RST;
      port_a_polarity_r <= POL_A_RST;
      port_b_polarity_r <= POL_B_RST;
    end else if (wr_en && (sel == SEL_PORT_A)) begin
      if (eff_idx == IDX_STATUS) begin
        // low two bits are reserved; target role is kept as written
        port_a_config_high_r <= {pwdata[7:2], 2'b00};
      end
      if (eff_idx == IDX_ID_LOW) begin
        port_a_polarity_r <= pwdata[7:0];
      end
    end else if (wr_en && (sel == SEL_PORT_B)) begin
      if (eff_idx == IDX_STATUS) begin
        // bit 13 and the low two bits are reserved on port B
        port_b_config_high_r <= {pwdata[7:6], 1'b0, pwdata[4:2], 2'b00};
      end
      if (eff_idx == IDX_ID_LOW) begin
        port_b_polarity_r <= pwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // DMA handshake selection
  // ------------------------------------------------------------------
  dma_mode_t a_mode;
  dma_mode_t b_mode;
  assign a_mode = dma_mode_t'(port_a_config_high_r[CFG_MODE_LSB +: 3]);
  assign b_mode = dma_mode_t'(port_b_config_high_r[CFG_MODE_LSB +: 3]);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      porta_dma_mode <= DMA_RSVD;
      portb_dma_mode <= DMA_RSVD;
      porta_mode_valid <= 1'b0;
      portb_mode_valid <= 1'b0;
    end else begin
      porta_dma_mode <= a_mode;
      portb_dma_mode <= b_mode;
      // reserved codes leave the port without a handshake
      porta_mode_valid <= (a_mode == DMA_VENDOR) || (a_mode == DMA_ATA) ||
        (a_mode == DMA_BURST);
      portb_mode_valid <= (b_mode == DMA_VENDOR) || (b_mode == DMA_ATA) ||
        (b_mode == DMA_BURST);
    end
  end

  // ------------------------------------------------------------------
  // parity on the two data buses
  // ------------------------------------------------------------------
  logic [1:0] a_gen;
  logic [1:0] b_gen;
  logic a_err;
  logic b_err;

  parity_unit #(
    .BYTES(2)
  ) u_parity_a (
    .data(porta_data_bus),
    .par_in(porta_par_in),
    .check_en(port_a_config_high_r[CFG_PARITY_BIT]),
    .odd(port_a_config_high_r[CFG_ODD_BIT]),
    .par_gen(a_gen),
    .par_err(a_err)
  );

  parity_unit #(
    .BYTES(2)
  ) u_parity_b (
    .data(portb_data_bus),
    .par_in(portb_par_in),
    .check_en(port_b_config_high_r[CFG_PARITY_BIT]),
    .odd(port_b_config_high_r[CFG_ODD_BIT]),
    .par_gen(b_gen),
    .par_err(b_err)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      porta_par_gen <= 2'b00;
      portb_par_gen <= 2'b00;
      porta_par_err <= 1'b0;
      portb_par_err <= 1'b0;
    end else begin
      porta_par_gen <= a_gen;
      portb_par_gen <= b_gen;
      porta_par_err <= a_err;
      portb_par_err <= b_err;
    end
  end

  // ------------------------------------------------------------------
  // control pin polarity; one cycle of latency, no synchroniser needed
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      porta_ctl_active <= 8'h00;
      portb_ctl_active <= 8'h00;
    end else begin
      porta_ctl_active <= porta_ctl_pins ^ port_a_polarity_r;
      portb_ctl_active <= portb_ctl_pins ^ port_b_polarity_r;
    end
  end

  assign byte_order_select = byte_order_r;

endmodule : port_status_config

`default_nettype wire

//--- sim/port_status_checker.sv
// port-level assertions for the port status and configuration block
`default_nettype none

module port_status_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] porta_data_bus,
  input wire logic [15:0] portb_data_bus,
  input wire logic [1:0] porta_par_gen,
  input wire logic [1:0] portb_par_gen,
  input wire logic [2:0] porta_dma_mode,
  input wire logic [2:0] portb_dma_mode,
  input wire logic porta_mode_valid,
  input wire logic portb_mode_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // read data may only move after a setup cycle
  rdata_hold_a:
    assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
  bad_addr_a:
    assert property (psel && penable && (paddr[1:0] != 2'h0 ||
      paddr[9:2] > 8'h12) |-> pslverr) else $error("bad access accepted");
  err_window_a:
    assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
  read_width_a:
    assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
  mode_a_a:
    assert property (porta_mode_valid ==
      (porta_dma_mode inside {3'h1, 3'h2, 3'h3})) else $error("mode a");
  mode_b_a:
    assert property (portb_mode_valid ==
      (portb_dma_mode inside {3'h1, 3'h2, 3'h3})) else $error("mode b");
  // odd setting cancels across the two lanes
  parity_a_a:
    assert property (!$past(reset) |-> ^porta_par_gen ==
      ^$past(porta_data_bus)) else $error("parity a");
  parity_b_a:
    assert property (!$past(reset) |-> ^portb_par_gen ==
      ^$past(portb_data_bus)) else $error("parity b");
endmodule : port_status_checker

`default_nettype wire

//--- sim/port_dma_model.sv
// far-side dma controller model for one 16-bit data port
`default_nettype none

module port_dma_model (
  input wire logic ref_clk,
  input wire logic [15:0] word,
  input wire logic odd,
  input wire logic bad,
  input wire logic busy,
  input wire logic [7:0] ctl_on,
  input wire logic [7:0] pol,
  output logic [15:0] data_bus = 16'h0000,
  output logic [1:0] par = 2'h0,
  output logic [7:0] ctl_pins = 8'h00,
  output logic path_busy = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  always @(posedge ref_clk) begin
    data_bus <= word;
    // bad corrupts the low lane only
    par <= {^word[15:8], ^word[7:0] ^ bad} ^ {2{odd}};
    // a set polarity bit drives the active line low
    ctl_pins <= ctl_on ^ pol;
    path_busy <= busy;
  end
endmodule : port_dma_model

`default_nettype wire

//--- sim/port_status_config_bench.sv
// self-checking bench for the port status and configuration block
`default_nettype none

module port_status_config_bench import port_status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary value, not a real part code
  localparam logic [15:0] ID_V = 16'hC3B7;
  logic ref_clk = 0;
  logic reset = 1;
  logic [11:0] paddr = '0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, bo;
  logic [31:0] pwdata = '0, prdata, cnt = '0, cmp = 32'h1, r = 32'd83687;
  logic [2:0] op_mode = '0, ma, mb;
  logic [9:0] ev = '0;
  logic a_one = 0, b_one = 0, a_busy = 0, b_busy = 0, odd = 0, bad = 0;
  logic pab, pbb, ea, eb, va, vb;
  logic [15:0] wa = '0, wb = '0, da, db;
  logic [1:0] pa, pb, ga, gb;
  logic [7:0] on_a = '0, on_b = '0, pol_a = 8'hFF, pol_b = 8'hDF, c;
  logic [7:0] pina, pinb, acta, actb;
  logic [31:0] q[$];
  int fails = 0, checked = 0;

  port_status_config #(.CHIP_IDENT(ID_V)) port_status_config_i (
    .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_mode(op_mode),
    .new_transfer(ev[0]), .final_word(ev[1]), .dec_end_code(ev[2]),
    .dec_code_error(ev[3]), .dec_record_start(ev[4]),
    .portb_count(cnt), .portb_compare(cmp), .portb_last_byte(ev[5]),
    .portb_one_byte(b_one), .portb_first_byte(ev[6]),
    .portb_path_busy(pbb), .porta_length_zero(ev[7]),
    .porta_last_byte(ev[8]), .porta_one_byte(a_one),
    .porta_first_byte(ev[9]), .porta_path_busy(pab),
    .porta_data_bus(da), .porta_par_in(pa), .portb_data_bus(db),
    .portb_par_in(pb), .porta_ctl_pins(pina), .portb_ctl_pins(pinb),
    .porta_ctl_active(acta), .portb_ctl_active(actb),
    .porta_par_gen(ga), .portb_par_gen(gb), .porta_par_err(ea),
    .portb_par_err(eb), .porta_dma_mode(ma), .portb_dma_mode(mb),
    .porta_mode_valid(va), .portb_mode_valid(vb), .byte_order_select(bo));

  port_dma_model port_dma_model_a_i (.ref_clk(ref_clk), .word(wa),
    .odd(odd), .bad(bad), .busy(a_busy), .ctl_on(on_a), .pol(pol_a),
    .data_bus(da), .par(pa), .ctl_pins(pina), .path_busy(pab));
  port_dma_model port_dma_model_b_i (.ref_clk(ref_clk), .word(wb),
    .odd(odd), .bad(bad), .busy(b_busy), .ctl_on(on_b), .pol(pol_b),
    .data_bus(db), .par(pb), .ctl_pins(pinb), .path_busy(pbb));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic test_done;
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    // no local limit: only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(0, a, 32'h0);
  endtask : rd

  task automatic pls(input logic [9:0] v);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= '0;
    @(posedge ref_clk);
  endtask : pls

  // read data is only valid in the access cycle
  always @(posedge ref_clk) begin
    if (psel && penable && !pwrite) begin
      chk(prdata, q.pop_front());
    end
  end

  initial begin
    #60us;
    fails++;
    test_done();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 0;
    rd(12'h004, 8'h0C);
    wr(12'h004, 8'hFF);
    rd(12'h004, 8'h0C);
    rd(12'h008, ID_V[7:0]);
    rd(12'h00C, ID_V[15:8]);
    rd(12'h000, 8'h00);
    rd(12'h005, 8'h00);
    rd(12'h080, 8'h00);
    wr(12'h040, 1);
    rd(12'h004, 8'h00);
    rd(12'h008, 8'hFF);
    rd(12'h00C, 8'h00);
    wr(12'h040, 2);
    rd(12'h008, 8'hDF);
    for (int i = 0; i < 8; i++) begin
      r = nx(r);
      c = {i[0], i[1], 1'b1, i[2:0], r[1:0]};
      wr(12'h040, 1);
      wr(12'h004, c);
      wr(12'h008, r[15:8]);
      rd(12'h004, {c[7:2], 2'b00});
      wr(12'h040, 2);
      wr(12'h004, c);
      wr(12'h008, r[23:16]);
      rd(12'h004, {c[7:6], 1'b0, c[4:2], 2'b00});
      wr(12'h040, 0);
      pol_a <= r[15:8];
      pol_b <= r[23:16];
      odd <= c[6];
      bad <= i[2];
      wa <= r[31:16];
      wb <= r[15:0];
      on_a <= r[7:0];
      on_b <= ~r[7:0];
      repeat (4) @(posedge ref_clk);
      chk(ma, i);
      chk(mb, i);
      chk(va, i inside {1, 2, 3});
      chk(vb, i inside {1, 2, 3});
      chk(ga, {^wa[15:8], ^wa[7:0]} ^ {2{c[6]}});
      chk(gb, {^wb[15:8], ^wb[7:0]} ^ {2{c[6]}});
      chk(ea, c[7] & i[2]);
      chk(eb, c[7] & i[2]);
      chk(acta, on_a);
      chk(actb, on_b);
    end
    wr(12'h048, 1);
    rd(12'h000, 8'h0C);
    chk(bo, 1);
    wr(12'h048, 0);
    cnt <= {1'b0, r[30:0]};
    cmp <= {1'b0, r[30:0]};
    a_busy <= 1;
    pls(10'h000);
    rd(12'h004, 8'h48);
    cmp <= {1'b0, r[30:0]} + 1;
    a_busy <= 0;
    b_busy <= 1;
    pls(10'h000);
    rd(12'h004, 8'h04);
    b_busy <= 0;
    op_mode <= OP_COMPRESS;
    pls(10'h080);
    rd(12'h004, 8'h0D);
    a_one <= 1;
    b_one <= 1;
    pls(10'h120);
    rd(12'h004, 8'h3F);
    pls(10'h240);
    rd(12'h004, 8'h0C);
    op_mode <= OP_DECOMP;
    pls(10'h024);
    rd(12'h004, 8'h8C);
    pls(10'h010);
    rd(12'h004, 8'h0C);
    pls(10'h008);
    rd(12'h004, 8'h8C);
    pls(10'h001);
    rd(12'h004, 8'h0C);
    op_mode <= OP_DECOMP_BYPASS;
    pls(10'h120);
    rd(12'h004, 8'h3F);
    pls(10'h001);
    rd(12'h004, 8'h0C);
    op_mode <= OP_COMPRESS;
    wr(12'h044, 32'hF);
    pls(10'h080);
    rd(12'h004, 8'h0C);
    pls(10'h002);
    rd(12'h004, 8'h0D);
    // mid-run reset must drop the record flag; only the status byte is read back
    reset <= 1;
    repeat (3) @(posedge ref_clk);
    reset <= 0;
    rd(12'h004, 8'h0C);
    test_done();
  end
endmodule : port_status_config_bench

bind port_status_config port_status_checker #(.ADDR_W(ADDR_W))
  port_status_checker_i (.ref_clk(ref_clk), .reset(reset),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .porta_data_bus(porta_data_bus), .portb_data_bus(portb_data_bus),
  .porta_par_gen(porta_par_gen), .portb_par_gen(portb_par_gen),
  .porta_dma_mode(porta_dma_mode), .portb_dma_mode(portb_dma_mode),
  .porta_mode_valid(porta_mode_valid),
  .portb_mode_valid(portb_mode_valid));

`default_nettype wire
